// ==== verilog/foc_cfg.svh ====
// Purpose: offsets, field positions, reset values for the fractional channel config block
// Assumes: register index is the printed register number, 16-bit words
// Notes:   definitions only
`ifndef FOC_CFG_SVH
`define FOC_CFG_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define FOC_ADDR_W        5
`define FOC_A_CTRL        5'h09
`define FOC_A_DIV         5'h0a
`define FOC_A_FRAC        5'h0b
`define FOC_B_CTRL        5'h0c
`define FOC_B_DIV         5'h0d
`define FOC_B_FRAC        5'h0e

// ----------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------
`define FOC_SRC_HI        14
`define FOC_SRC_LO        13
`define FOC_PRE_HI        12
`define FOC_PRE_LO        10
`define FOC_FRAC_ON       9
`define FOC_EDGE_RATE     8
`define FOC_NEG_ON        7
`define FOC_POS_ON        6
`define FOC_DRV_HI        4
`define FOC_DRV_LO        3
`define FOC_OUT_HI        2
`define FOC_OUT_LO        1
`define FOC_SUPPLY        0

// ----------------------------------------------------------------
// divider word fields
// ----------------------------------------------------------------
`define FOC_IDIV_HI       11
`define FOC_IDIV_LO       4
`define FOC_FHI_HI        3
`define FOC_FHI_LO        0

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define FOC_CTRL_RST      16'h0000
`define FOC_DIV_RST       16'h0000
`define FOC_FRAC_RST      16'h0000
`define FOC_CTRL_MASK     16'h7fdf
`define FOC_DIV_MASK      16'h0fff
`define FOC_FRAC_MASK     16'hffff

`endif

// ==== verilog/foc_pkg.sv ====
// Purpose: shared types of the fractional channel config block
// Assumes: nothing
// Notes:   codes match the control word encodings
`default_nettype none
package foc_pkg;

  typedef enum logic [1:0] {
    FOC_SRC_PLL  = 2'b00,
    FOC_SRC_PRI  = 2'b01,
    FOC_SRC_SEC  = 2'b10,
    FOC_SRC_PLL2 = 2'b11
  } foc_src_e;

  typedef enum logic [1:0] {
    FOC_DRV_LVDS  = 2'b00,
    FOC_DRV_LVDS2 = 2'b01,
    FOC_DRV_CMOS  = 2'b10,
    FOC_DRV_HCSL  = 2'b11
  } foc_drv_e;

  typedef enum logic [1:0] {
    FOC_OUT_OFF  = 2'b00,
    FOC_OUT_RUN  = 2'b01,
    FOC_OUT_LOW  = 2'b10,
    FOC_OUT_HIGH = 2'b11
  } foc_out_e;

  typedef struct packed {
    logic        en;
    logic [4:0]  addr;
    logic [15:0] data;
  } foc_wr_s;

  typedef struct packed {
    foc_drv_e driver_type;
    logic     edge_rate;
    logic     pos_on;
    logic     neg_on;
    logic     supply_level;
  } foc_drv_s;

endpackage
`default_nettype wire

// ==== verilog/foc_top.sv ====
// Purpose: config words and clock path of two fractional output channels (a, b)
// Assumes: source clocks are slow enough to be oversampled by mclk
// Notes:   both edges of the source count, so odd ratios keep 50% duty
//          reserved prescale codes run as divide by 1
`include "foc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - source code 00 or 11 picks pll, 01 primary input, 10 secondary input.
// - prescale code 000 divides by 2, 001 by 3, 111 by 1.
// - channel a prescaler bypassed while its fraction enable is clear.
// - channel b prescaler bypassed while its fraction enable is clear.
// - one control bit turns the fractional divider off at 0, on at 1.
// - output state 00 off, 01 divided clock, 10 static low, 11 static high.
// - integer field bits 11..4 divides by programmed value plus one.
// - 20-bit fraction: top four bits in divider word, low sixteen next word.
// - driver type 00/01 low-swing differential, 10 cmos, 11 hcsl.
// - negative single-ended output only enabled while positive side enabled.
// - one bit enables the positive single-ended output when set.
// - one bit selects normal edge rate at 0, slow at 1.
// - channel b control word has the same layout as channel a.
module foc_top (
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            pll_clk,
  input  wire logic            pri_clk,
  input  wire logic            sec_clk,
  input  wire foc_pkg::foc_wr_s wr,
  input  wire logic [4:0]      rd_addr,
  output logic [15:0]          rd_data,
  output logic                 chan_a_clk,
  output logic                 chan_a_oe,
  output foc_pkg::foc_drv_s    chan_a_drv,
  output logic                 chan_b_clk,
  output logic                 chan_b_oe,
  output foc_pkg::foc_drv_s    chan_b_drv
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // events per prescale half-period minus one; reserved codes run as /1
  function automatic logic [1:0] pre_last(input logic [2:0] code, input logic frac_on);
    logic [1:0] r;
    r = 2'h0;
    if (frac_on) begin
      unique case (code)
        3'h0:    r = 2'h1;
        3'h1:    r = 2'h2;
        default: r = 2'h0;
      endcase
    end
    return r;
  endfunction

  function automatic logic src_event(input logic [1:0] sel, input logic [2:0] ev);
    logic r;
    r = ev[0];
    unique case (sel)
      2'b01:   r = ev[1];
      2'b10:   r = ev[2];
      default: r = ev[0];
    endcase
    return r;
  endfunction

  function automatic foc_pkg::foc_drv_s drive_of(input logic [15:0] ctl);
    foc_pkg::foc_drv_s d;
    d.driver_type  = foc_pkg::foc_drv_e'(ctl[`FOC_DRV_HI:`FOC_DRV_LO]);
    d.edge_rate    = ctl[`FOC_EDGE_RATE];
    d.pos_on       = ctl[`FOC_POS_ON];
    d.neg_on       = ctl[`FOC_NEG_ON] & ctl[`FOC_POS_ON];
    d.supply_level = ctl[`FOC_SUPPLY];
    return d;
  endfunction

  // ----------------------------------------------------------------
  // configuration words
  // ----------------------------------------------------------------
  logic [15:0] ctrl_reg [2];
  logic [15:0] div_reg  [2];
  logic [15:0] frac_reg [2];

  // reserved bits are dropped on write so they always read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg[0] <= `FOC_CTRL_RST;
      ctrl_reg[1] <= `FOC_CTRL_RST;
      div_reg[0]  <= `FOC_DIV_RST;
      div_reg[1]  <= `FOC_DIV_RST;
      frac_reg[0] <= `FOC_FRAC_RST;
      frac_reg[1] <= `FOC_FRAC_RST;
    end else if (wr.en) begin
      unique case (wr.addr)
        `FOC_A_CTRL: ctrl_reg[0] <= wr.data & `FOC_CTRL_MASK;
        `FOC_B_CTRL: ctrl_reg[1] <= wr.data & `FOC_CTRL_MASK;
        `FOC_A_DIV:  div_reg[0]  <= wr.data & `FOC_DIV_MASK;
        `FOC_B_DIV:  div_reg[1]  <= wr.data & `FOC_DIV_MASK;
        `FOC_A_FRAC: frac_reg[0] <= wr.data & `FOC_FRAC_MASK;
        `FOC_B_FRAC: frac_reg[1] <= wr.data & `FOC_FRAC_MASK;
        default:     ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else begin
      unique case (rd_addr)
        `FOC_A_CTRL: rd_data <= ctrl_reg[0];
        `FOC_B_CTRL: rd_data <= ctrl_reg[1];
        `FOC_A_DIV:  rd_data <= div_reg[0];
        `FOC_B_DIV:  rd_data <= div_reg[1];
        `FOC_A_FRAC: rd_data <= frac_reg[0];
        `FOC_B_FRAC: rd_data <= frac_reg[1];
        default:     rd_data <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // source sampling
  // ----------------------------------------------------------------
  // index 0 pll, 1 primary, 2 secondary
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] lvl_reg;
  logic [2:0] lvl_next;
  logic [2:0] src_ev;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
    end else begin
      s1_reg <= {sec_clk, pri_clk, pll_clk};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a level counts only once stages two and three agree
  always_comb begin
    lvl_next = lvl_reg;
    for (int i = 0; i < 3; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        lvl_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_reg <= 3'h0;
    end else begin
      lvl_reg <= lvl_next;
    end
  end

  assign src_ev = lvl_next ^ lvl_reg;

  // ----------------------------------------------------------------
  // per-channel dividers
  // ----------------------------------------------------------------
  logic [1:0]  ch_clk;
  logic [1:0]  ch_oe;
  foc_pkg::foc_drv_s ch_drv [2];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [1:0]  pre_cnt_reg;
    logic [7:0]  div_cnt_reg;
    logic [19:0] acc_reg;
    logic        extra_reg;
    logic        half_reg;
    logic        clk_reg;
    logic        oe_reg;
    foc_pkg::foc_drv_s drv_reg;
    logic        frac_on;
    logic        ev_in;
    logic        pre_ev;
    logic        wrap;
    logic        at_end;
    logic [19:0] frac;
    logic [20:0] acc_sum;
    logic [7:0]  idiv;
    foc_pkg::foc_out_e ostate;

    assign frac_on = ctrl_reg[c][`FOC_FRAC_ON];
    assign ev_in   = src_event(ctrl_reg[c][`FOC_SRC_HI:`FOC_SRC_LO], src_ev);
    // >= so a counter left above a newly written setting ends at once
    assign pre_ev  = ev_in &&
                     (pre_cnt_reg >= pre_last(ctrl_reg[c][`FOC_PRE_HI:`FOC_PRE_LO], frac_on));
    assign idiv    = div_reg[c][`FOC_IDIV_HI:`FOC_IDIV_LO];
    assign frac    = {div_reg[c][`FOC_FHI_HI:`FOC_FHI_LO], frac_reg[c]};
    // half-period is idiv+1 events, one more when the fraction carried
    assign at_end  = pre_ev && (div_cnt_reg >= idiv);
    assign wrap    = at_end && !extra_reg;
    assign acc_sum = {1'b0, acc_reg} + {1'b0, frac};
    assign ostate  = foc_pkg::foc_out_e'(ctrl_reg[c][`FOC_OUT_HI:`FOC_OUT_LO]);

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        pre_cnt_reg <= 2'h0;
      end else if (pre_ev) begin
        pre_cnt_reg <= 2'h0;
      end else if (ev_in) begin
        pre_cnt_reg <= pre_cnt_reg + 2'h1;
      end
    end

    // counter holds at its end value while extra_reg spends the carried event
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        div_cnt_reg <= 8'h00;
      end else if (wrap) begin
        div_cnt_reg <= 8'h00;
      end else if (pre_ev && !at_end) begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end

    // set only on a wrap, cleared only on an end without wrap: never both
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        extra_reg <= 1'b0;
      end else if (wrap) begin
        extra_reg <= frac_on & acc_sum[20];
      end else if (at_end) begin
        extra_reg <= 1'b0;
      end
    end

    // fraction is taken only when enabled; accumulator clears otherwise
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        acc_reg <= 20'h00000;
      end else if (!frac_on) begin
        acc_reg <= 20'h00000;
      end else if (wrap) begin
        acc_reg <= acc_sum[19:0];
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        half_reg <= 1'b0;
      end else if (wrap) begin
        half_reg <= ~half_reg;
      end
    end

    // static levels keep oe high; only code 00 leaves the pin undriven
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        clk_reg <= 1'b0;
      end else begin
        unique case (ostate)
          foc_pkg::FOC_OUT_OFF:  clk_reg <= 1'b0;
          foc_pkg::FOC_OUT_RUN:  clk_reg <= half_reg;
          foc_pkg::FOC_OUT_LOW:  clk_reg <= 1'b0;
          foc_pkg::FOC_OUT_HIGH: clk_reg <= 1'b1;
        endcase
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        oe_reg <= 1'b0;
      end else begin
        oe_reg <= (ostate != foc_pkg::FOC_OUT_OFF);
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        drv_reg <= '0;
      end else begin
        drv_reg <= drive_of(ctrl_reg[c]);
      end
    end

    assign ch_clk[c] = clk_reg;
    assign ch_oe[c]  = oe_reg;
    assign ch_drv[c] = drv_reg;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign chan_a_clk = ch_clk[0];
  assign chan_a_oe  = ch_oe[0];
  assign chan_a_drv = ch_drv[0];
  assign chan_b_clk = ch_clk[1];
  assign chan_b_oe  = ch_oe[1];
  assign chan_b_drv = ch_drv[1];

endmodule
`default_nettype wire

// ==== bench/foc_top_props.sv ====
// Purpose: port checks of the fractional channel config block
// Assumes: a write taken at edge e shows on registered outputs at edge e+2
// Notes:   bound to foc_top after the module
`include "foc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module foc_top_props (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire foc_pkg::foc_wr_s  wr,
  input wire logic [4:0]        rd_addr,
  input wire logic [15:0]       rd_data,
  input wire logic              chan_a_clk,
  input wire logic              chan_a_oe,
  input wire foc_pkg::foc_drv_s chan_a_drv,
  input wire logic              chan_b_clk,
  input wire logic              chan_b_oe,
  input wire foc_pkg::foc_drv_s chan_b_drv
);
  logic a_wr_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] mask_of(input logic [4:0] a);
    case (a)
      `FOC_A_CTRL, `FOC_B_CTRL: mask_of = `FOC_CTRL_MASK;
      `FOC_A_DIV, `FOC_B_DIV:   mask_of = `FOC_DIV_MASK;
      `FOC_A_FRAC, `FOC_B_FRAC: mask_of = `FOC_FRAC_MASK;
      default:                  mask_of = 16'h0000;
    endcase
  endfunction
  // oe may only move two edges after a control write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) a_wr_q <= 1'b0;
    else a_wr_q <= wr.en && wr.addr == `FOC_A_CTRL;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_neg_a;
    chan_a_drv.neg_on |-> chan_a_drv.pos_on;
  endproperty
  a_neg_a: assert property (p_neg_a) else $error("a neg without pos");
  property p_neg_b;
    chan_b_drv.neg_on |-> chan_b_drv.pos_on;
  endproperty
  a_neg_b: assert property (p_neg_b) else $error("b neg without pos");
  property p_ctrl_a;
    logic [1:0] s;
    (wr.en && wr.addr == `FOC_A_CTRL, s = wr.data[2:1]) |-> ##2
      chan_a_oe == (s != 2'b00) && (s == 2'b01 || chan_a_clk == (s == 2'b11));
  endproperty
  a_ctrl_a: assert property (p_ctrl_a) else $error("a output state");
  property p_ctrl_b;
    logic [1:0] s;
    (wr.en && wr.addr == `FOC_B_CTRL, s = wr.data[2:1]) |-> ##2
      chan_b_oe == (s != 2'b00) && (s == 2'b01 || chan_b_clk == (s == 2'b11));
  endproperty
  a_ctrl_b: assert property (p_ctrl_b) else $error("b output state");
  property p_drv_a;
    logic [15:0] d;
    (wr.en && wr.addr == `FOC_A_CTRL, d = wr.data) |-> ##2
      chan_a_drv == {d[4:3], d[8], d[6], d[7] & d[6], d[0]};
  endproperty
  a_drv_a: assert property (p_drv_a) else $error("a driver fields");
  property p_readback;
    logic [4:0]  a;
    logic [15:0] d;
    (wr.en && mask_of(wr.addr) != 16'h0000, a = wr.addr, d = wr.data)
      ##1 (rd_addr == a && !(wr.en && wr.addr == a)) |=> rd_data == (d & mask_of(a));
  endproperty
  a_readback: assert property (p_readback) else $error("readback");
  property p_resv;
    1'b1 |=> (rd_data & ~mask_of($past(rd_addr))) == 16'h0000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit read set");
  property p_oe_hold;
    $changed(chan_a_oe) |-> $past(a_wr_q);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("a oe moved unasked");
endmodule
bind foc_top foc_top_props u_foc_top_props (
  .mclk, .rst_n, .wr, .rd_addr, .rd_data, .chan_a_clk, .chan_a_oe, .chan_a_drv,
  .chan_b_clk, .chan_b_oe, .chan_b_drv);
`default_nettype wire

// ==== bench/foc_top_tb.sv ====
// Purpose: self-checking bench of the fractional channel config block
// Assumes: sources toggle every 8 mclk, far below the filter limit
// Notes:   rates judged by output toggle counts, one toggle tolerance
`include "foc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module foc_top_tb;
  typedef struct packed {
    logic        ch;
    logic [1:0]  sel;
    logic [2:0]  pre;
    logic        fon;
    logic [7:0]  idiv;
    logic [19:0] frac;
    logic [7:0]  k2;
  } foc_row_s;
  logic              mclk;
  logic              rst_n;
  logic [2:0]        src;
  foc_pkg::foc_wr_s  wr;
  logic [4:0]        rd_addr;
  logic [15:0]       rd_data;
  logic              chan_a_clk;
  logic              chan_a_oe;
  foc_pkg::foc_drv_s chan_a_drv;
  logic              chan_b_clk;
  logic              chan_b_oe;
  foc_pkg::foc_drv_s chan_b_drv;
  int                num_errors;
  int                check_count;
  // k2: twice the source events per output toggle
  foc_row_s          rows [7] = '{
    '{1'b0, 2'b00, 3'b000, 1'b0, 8'h00, 20'h00000, 8'h02},
    '{1'b0, 2'b01, 3'b001, 1'b0, 8'h02, 20'h00000, 8'h06},
    '{1'b0, 2'b10, 3'b000, 1'b1, 8'h01, 20'h00000, 8'h08},
    '{1'b0, 2'b11, 3'b001, 1'b1, 8'h00, 20'h00000, 8'h06},
    '{1'b0, 2'b00, 3'b111, 1'b1, 8'h01, 20'h80000, 8'h05},
    '{1'b1, 2'b01, 3'b000, 1'b0, 8'h03, 20'h00000, 8'h08},
    '{1'b1, 2'b10, 3'b001, 1'b1, 8'h01, 20'h00000, 8'h0c}};
  foc_top u_foc_top (
    .mclk(mclk), .rst_n(rst_n), .pll_clk(src[0]), .pri_clk(src[1]), .sec_clk(src[2]),
    .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data), .chan_a_clk(chan_a_clk),
    .chan_a_oe(chan_a_oe), .chan_a_drv(chan_a_drv), .chan_b_clk(chan_b_clk),
    .chan_b_oe(chan_b_oe), .chan_b_drv(chan_b_drv));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int exp);
    check_count++;
    if (got < exp - 1 || got > exp + 1) begin
      num_errors++;
      $display("[FAIL] %0t toggles %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= '{en: 1'b1, addr: a, data: d};
    @(posedge mclk);
    wr.en <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge mclk);
    rd_addr <= a;
    @(posedge mclk);
    @(negedge mclk);
    chk(rd_data, exp);
  endtask
  task automatic run_row(input foc_row_s r);
    logic [4:0] base;
    int         idx;
    int         n;
    logic       prev;
    base = r.ch ? `FOC_B_CTRL : `FOC_A_CTRL;
    idx = (r.sel == 2'b01) ? 1 : (r.sel == 2'b10) ? 2 : 0;
    n = 0;
    wr_reg(base, {1'b0, r.sel, r.pre, r.fon, 6'h00, 2'b01, 1'b0});
    wr_reg(base + 5'h01, {4'h0, r.idiv, r.frac[19:16]});
    wr_reg(base + 5'h02, r.frac[15:0]);
    repeat (8) @(negedge mclk);
    prev = r.ch ? chan_b_clk : chan_a_clk;
    repeat (60) begin
      @(posedge mclk);
      src[idx] <= ~src[idx];
      repeat (8) begin
        @(negedge mclk);
        if ((r.ch ? chan_b_clk : chan_a_clk) !== prev) n++;
        prev = r.ch ? chan_b_clk : chan_a_clk;
      end
    end
    chk_near(n, 120 / int'(r.k2));
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #500000;
    num_errors++;
    $display("[FAIL] %0t run timed out", $time);
    print_verdict();
  end
  initial begin
    logic [1:0]  t;
    logic [15:0] c;
    rst_n = 1'b0;
    src = 3'b000;
    wr = '0;
    rd_addr = 5'h00;
    num_errors = 0;
    check_count = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 9; a < 15; a++) begin
      c = (a % 3 == 0) ? `FOC_CTRL_MASK : (a % 3 == 1) ? `FOC_DIV_MASK : `FOC_FRAC_MASK;
      rd_chk(5'(a), 16'h0000);
      wr_reg(5'(a), c);
      rd_chk(5'(a), c);
    end
    wr_reg(5'h0f, 16'hffff);
    rd_chk(5'h0f, 16'h0000);
    rd_chk(5'h08, 16'h0000);
    for (int i = 0; i < 7; i++) run_row(rows[i]); // rates
    for (int i = 0; i < 4; i++) begin
      t = 2'(i);
      c = {7'h00, t[0], t[1], t[1], 1'b0, t, t, t[0]};
      wr_reg(`FOC_A_CTRL, c);
      wr_reg(`FOC_B_CTRL, c);
      repeat (3) @(negedge mclk);
      chk({4'h0, chan_a_drv, chan_b_drv}, {4'h0, {2{t, t[0], t[1], t[1], t[0]}}});
      chk({14'h0, chan_a_oe, chan_b_oe}, {14'h0, {2{t != 2'b00}}});
      if (t != 2'b01) chk({14'h0, chan_a_clk, chan_b_clk}, {14'h0, {2{t == 2'b11}}});
    end
    // second reset in mid-run, outputs were high
    @(posedge mclk);
    rst_n <= 1'b0;
    @(negedge mclk);
    chk({14'h0, chan_a_oe, chan_b_oe}, 16'h0000);
    @(posedge mclk);
    @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(`FOC_B_CTRL, 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
